/* File: core/port_tag_ratelimit_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module port_tag_ratelimit_ctrl
  import port_tag_ratelimit_pkg::*;
#(
  parameter int NPORT = 3
)
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        port3_rx_valid_strap_pin,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  input  wire logic [2:0]  rx_tagged,
  input  wire logic [35:0] rx_vid,
  input  wire logic [2:0]  rx_bcast,
  input  wire logic [2:0]  rx_mcast,
  input  wire logic [2:0]  rx_flood,
  output logic      [47:0] port_default_tag,
  output logic      [35:0] lookup_vid,
  output logic      [2:0]  drop_frame,
  output logic      [2:0]  limit_count,
  output logic      [14:0] overhead_bytes,
  output logic             port3_mii_mac_mode,
  output logic             port1_self_filter_en,
  output logic             port2_self_filter_en
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Offsets and port widths exist for exactly three ports
  generate
    if (NPORT != 3)
    begin : g_bad_nport
      $error("NPORT must be 3");
    end
  endgenerate

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  logic strap_s1_r;
  logic strap_s2_r;
  logic strap_taken_r;

  always_ff @(posedge clock)
  begin
    strap_s1_r <= port3_rx_valid_strap_pin;
    strap_s2_r <= strap_s1_r;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      strap_taken_r <= 1'b0;
    else
      strap_taken_r <= 1'b1;
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] tag_high_r [NPORT];
  logic [7:0] tag_low_r  [NPORT];
  logic [7:0] ctrl5_r    [NPORT];
  logic [7:0] ofs_high   [NPORT];
  logic [7:0] ofs_low    [NPORT];
  logic [7:0] ofs_ctrl5  [NPORT];

  assign ofs_high[0]  = P1_TAG_HIGH_OFS;
  assign ofs_high[1]  = P2_TAG_HIGH_OFS;
  assign ofs_high[2]  = P3_TAG_HIGH_OFS;
  assign ofs_low[0]   = P1_TAG_LOW_OFS;
  assign ofs_low[1]   = P2_TAG_LOW_OFS;
  assign ofs_low[2]   = P3_TAG_LOW_OFS;
  assign ofs_ctrl5[0] = P1_CTRL5_OFS;
  assign ofs_ctrl5[1] = P2_CTRL5_OFS;
  assign ofs_ctrl5[2] = P3_CTRL5_OFS;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [NPORT-1:0] sel_high;
  logic [NPORT-1:0] sel_low;
  logic [NPORT-1:0] sel_ctrl5;

  genvar p;
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_decode
      assign sel_high[p]  = (reg_addr == ofs_high[p]);
      assign sel_low[p]   = (reg_addr == ofs_low[p]);
      assign sel_ctrl5[p] = (reg_addr == ofs_ctrl5[p]);
    end
  endgenerate

  // ****************************************************************
  // Per-port registers
  // ****************************************************************
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_regs
      logic [7:0] ctrl5_mask;

      // Port 3 keeps bit 7; ports 1 and 2 keep it zero
      assign ctrl5_mask = (p == 2) ? 8'hff : 8'h7f;

      // Tag high byte: priority, CFI, VID upper nibble
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          tag_high_r[p] <= TAG_HIGH_RST;
        end
        else if (reg_wr && sel_high[p])
        begin
          tag_high_r[p] <= reg_wdata;
        end
      end

      // Tag low byte: VID lower byte
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          tag_low_r[p] <= TAG_LOW_RST;
        end
        else if (reg_wr && sel_low[p])
        begin
          tag_low_r[p] <= reg_wdata;
        end
      end

      // Control-5; port 3 takes the strap once after reset
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          ctrl5_r[p] <= CTRL5_RST;
        end
        else if (p == 2 && !strap_taken_r)
        begin
          ctrl5_r[p] <= CTRL5_RST | (8'(!strap_s2_r) << MII_MAC_BIT);
        end
        else if (reg_wr && sel_ctrl5[p])
        begin
          ctrl5_r[p] <= reg_wdata & ctrl5_mask;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Default tag and lookup VID
  // ****************************************************************
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_vid
      logic [11:0] dflt_vid;
      logic [11:0] rx_vid_p;
      logic        null_vid;
      logic        use_dflt;

      // Tag out for untagged ingress and egress insertion
      assign port_default_tag[16*p +: 16] =
        {tag_high_r[p], tag_low_r[p]};

      assign dflt_vid = {tag_high_r[p][VID_HI_MSB:0], tag_low_r[p]};
      assign rx_vid_p = rx_vid[12*p +: 12];
      assign null_vid = (rx_vid_p == 12'h000);
      assign use_dflt = !rx_tagged[p] || null_vid;
      assign lookup_vid[12*p +: 12] = use_dflt ? dflt_vid : rx_vid_p;
    end
  endgenerate

  // ****************************************************************
  // Tagged frame drop
  // ****************************************************************
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_drop
      assign drop_frame[p] = ctrl5_r[p][DROP_TAG_BIT] & rx_tagged[p];
    end
  endgenerate

  // ****************************************************************
  // Ingress limit class
  // ****************************************************************
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_limit
      limit_mode_t mode;
      logic        in_class;

      assign mode = limit_mode_t'(ctrl5_r[p][LMODE_MSB:LMODE_LSB]);

      always_comb
      begin
        case (mode)
          LIMIT_ALL:
          begin
            in_class = 1'b1;
          end
          LIMIT_FLOOD:
          begin
            in_class = rx_bcast[p] | rx_mcast[p] | rx_flood[p];
          end
          LIMIT_MCAST:
          begin
            in_class = rx_bcast[p] | rx_mcast[p];
          end
          LIMIT_BCAST:
          begin
            in_class = rx_bcast[p];
          end
          default:
          begin
            in_class = 1'b1;
          end
        endcase
      end

      assign limit_count[p] = in_class;
    end
  endgenerate

  // ****************************************************************
  // Rate accounting overhead
  // ****************************************************************
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_ovh
      logic [4:0] gap_add;
      logic [4:0] pre_add;

      assign gap_add = ctrl5_r[p][GAP_BIT] ? GAP_BYTES : 5'h00;
      assign pre_add = ctrl5_r[p][PRE_BIT] ? PREAMBLE_BYTES : 5'h00;
      // Sum peaks at twenty, so five bits never overflow
      assign overhead_bytes[5*p +: 5] = 5'(gap_add + pre_add);
    end
  endgenerate

  // ****************************************************************
  // Mode and filter outputs
  // ****************************************************************
  // Self-filter bits live in the port 1 and port 2 registers only
  assign port3_mii_mac_mode   = ctrl5_r[2][MII_MAC_BIT];
  assign port1_self_filter_en =
    ctrl5_r[0][SELF1_BIT] | ctrl5_r[1][SELF1_BIT];
  assign port2_self_filter_en =
    ctrl5_r[0][SELF2_BIT] | ctrl5_r[1][SELF2_BIT];

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] rdata_nxt;
  logic       hit_nxt;

  // Unmapped offsets read as zero with the hit flag low
  always_comb
  begin
    rdata_nxt = 8'h00;
    hit_nxt   = 1'b0;
    for (int i = 0; i < NPORT; i++)
    begin
      if (sel_high[i])
      begin
        rdata_nxt = tag_high_r[i];
        hit_nxt   = 1'b1;
      end
      if (sel_low[i])
      begin
        rdata_nxt = tag_low_r[i];
        hit_nxt   = 1'b1;
      end
      if (sel_ctrl5[i])
      begin
        rdata_nxt = ctrl5_r[i];
        hit_nxt   = 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      reg_hit <= 1'b0;
    end
    else if (reg_rd)
    begin
      reg_hit <= hit_nxt;
    end
  end

endmodule // port_tag_ratelimit_ctrl

`default_nettype wire

/* File: core/port_tag_ratelimit_pkg.sv */
package port_tag_ratelimit_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] P1_TAG_HIGH_OFS = 8'h13;
  localparam logic [7:0] P1_TAG_LOW_OFS  = 8'h14;
  localparam logic [7:0] P1_CTRL5_OFS    = 8'h15;
  localparam logic [7:0] P2_TAG_HIGH_OFS = 8'h23;
  localparam logic [7:0] P2_TAG_LOW_OFS  = 8'h24;
  localparam logic [7:0] P2_CTRL5_OFS    = 8'h25;
  localparam logic [7:0] P3_TAG_HIGH_OFS = 8'h33;
  localparam logic [7:0] P3_TAG_LOW_OFS  = 8'h34;
  localparam logic [7:0] P3_CTRL5_OFS    = 8'h35;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] TAG_HIGH_RST = 8'h00;
  localparam logic [7:0] TAG_LOW_RST  = 8'h01;
  localparam logic [7:0] CTRL5_RST    = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PRIO_MSB     = 7;
  localparam int PRIO_LSB     = 5;
  localparam int CFI_BIT      = 4;
  localparam int VID_HI_MSB   = 3;
  localparam int MII_MAC_BIT  = 7;
  localparam int SELF1_BIT    = 6;
  localparam int SELF2_BIT    = 5;
  localparam int DROP_TAG_BIT = 4;
  localparam int LMODE_MSB    = 3;
  localparam int LMODE_LSB    = 2;
  localparam int GAP_BIT      = 1;
  localparam int PRE_BIT      = 0;

  // ****************************************************************
  // Accounting figures
  // ****************************************************************
  localparam logic [4:0] GAP_BYTES      = 5'h0c;
  localparam logic [4:0] PREAMBLE_BYTES = 5'h08;

  // ****************************************************************
  // Ingress limit modes
  // ****************************************************************
  typedef enum logic [1:0]
  {
    LIMIT_ALL   = 2'h0,
    LIMIT_FLOOD = 2'h1,
    LIMIT_MCAST = 2'h2,
    LIMIT_BCAST = 2'h3
  } limit_mode_t;

endpackage

/* File: verif/ptrc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checker
// ****************
module ptrc_chk
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        port3_rx_valid_strap_pin,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [2:0]  rx_tagged,
  input wire logic [35:0] rx_vid,
  input wire logic [47:0] port_default_tag,
  input wire logic [35:0] lookup_vid,
  input wire logic [2:0]  drop_frame,
  input wire logic        port3_mii_mac_mode,
  input wire logic        port1_self_filter_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  rst_tag_a: assert property (disable iff (1'b0)
    reset |=> port_default_tag == 48'h000100010001) else $error("reset");
  low_wr_a: assert property (reg_wr && reg_addr == 8'h14
    |=> port_default_tag[7:0] == $past(reg_wdata)) else $error("low");
  high_wr_a: assert property (reg_wr && reg_addr == 8'h23
    |=> port_default_tag[31:24] == $past(reg_wdata)) else $error("high");
  mii_wr_a: assert property (reg_wr && reg_addr == 8'h35
    && !$past(reset) |=> port3_mii_mac_mode == $past(reg_wdata[7]))
    else $error("mii");
  strap_load_a: assert property ($fell(reset)
    |=> port3_mii_mac_mode == !$past(port3_rx_valid_strap_pin, 3))
    else $error("strap");
  self_en_a: assert property (reg_wr && reg_addr == 8'h15
    && reg_wdata[6] |=> port1_self_filter_en) else $error("self");
  drop_only_a: assert property ((drop_frame & ~rx_tagged) == 3'h0)
    else $error("drop");
  dflt_vid_a: assert property (!rx_tagged[0] || rx_vid[11:0] == 12'h0
    |-> lookup_vid[11:0] == port_default_tag[11:0]) else $error("dflt");
  rx_vid_a: assert property (rx_tagged[0] && rx_vid[11:0] != 12'h0
    |-> lookup_vid[11:0] == rx_vid[11:0]) else $error("vid");
endmodule // ptrc_chk
bind port_tag_ratelimit_ctrl ptrc_chk u_chk (.*);
`default_nettype wire

/* File: verif/tb_port_tag_ratelimit_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_port_tag_ratelimit_ctrl;
  logic        clock = 0, reset = 1, strap = 1, wr = 0, rd = 0, hit;
  logic [7:0]  addr = 0, wdata = 0, rdata;
  logic [2:0]  tagd = 0, bc = 0, mc = 0, fl = 0, drop, lim;
  logic [35:0] vid = 0, lvid;
  logic [47:0] tag;
  logic [14:0] ovh;
  logic        mac, s1, s2;
  int          fails = 0, total_checks = 0;
  port_tag_ratelimit_ctrl DUT (.clock, .reset,
    .port3_rx_valid_strap_pin(strap), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit),
    .rx_tagged(tagd), .rx_vid(vid), .rx_bcast(bc), .rx_mcast(mc),
    .rx_flood(fl), .port_default_tag(tag), .lookup_vid(lvid),
    .drop_frame(drop), .limit_count(lim), .overhead_bytes(ovh),
    .port3_mii_mac_mode(mac), .port1_self_filter_en(s1),
    .port2_self_filter_en(s2));
  initial forever #4 clock = ~clock;
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string n, input logic [47:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge clock);
    {wr, rd, addr, wdata} = {w, !w, a, d};
    @(negedge clock);
    {wr, rd} = 2'b00;
  endtask
  task automatic t_reset(input logic s);
    logic [7:0] e;
    strap = s;
    reset = 1;
    repeat (10) @(negedge clock);
    reset = 0;
    repeat (2) @(negedge clock);
    for (int i = 0; i < 9; i++)
    begin
      acc(0, 8'(8'h13 + 16 * (i / 3) + i % 3), 8'h00);
      e = 8'(i % 3 == 1) | ((i == 8) ? {!s, 7'h00} : 8'h00);
      chk("rdata", e, rdata);
      chk("hit", 1'b1, hit);
    end
    acc(0, 8'h40, 8'h00);
    chk("miss", 9'h000, {hit, rdata});
    chk("tag", 48'h000100010001, tag);
  endtask
  task automatic t_tag;
    acc(1, 8'h13, 8'h3c);
    acc(1, 8'h14, 8'hc3);
    acc(1, 8'h23, 8'h6e);
    chk("tag1", 16'h3cc3, tag[15:0]);
    chk("dvid1", 12'hcc3, lvid[11:0]);
    chk("tag2h", 8'h6e, tag[31:24]);
    acc(1, 8'h33, 8'ha5);
    acc(1, 8'h34, 8'h5a);
    chk("tag3", 16'ha55a, tag[47:32]);
    chk("dvid", 12'h55a, lvid[35:24]);
    tagd = 3'h4;
    #1 chk("null", 12'h55a, lvid[35:24]);
    @(negedge clock);
    vid = 36'h123000456;
    #1 chk("vid", 12'h123, lvid[35:24]);
  endtask
  task automatic t_ctrl;
    acc(1, 8'h25, 8'h9f);
    acc(0, 8'h25, 8'h00);
    chk("bit7", 8'h1f, rdata);
    tagd = 3'h7;
    #1 chk("drop", 3'h2, drop);
    chk("vid1", 12'h456, lvid[11:0]);
    chk("ovh2", 5'h14, ovh[9:5]);
    acc(1, 8'h15, 8'h62);
    chk("self", 2'h3, {s2, s1});
    chk("ovh1", 5'h0c, ovh[4:0]);
    acc(1, 8'h35, 8'hed);
    acc(1, 8'h15, 8'h01);
    chk("p3", 3'h4, {mac, s2, s1});
    chk("ovh", 15'h2288, ovh);
  endtask
  task automatic t_limit;
    logic e;
    for (int m = 0; m < 4; m++)
    begin
      acc(1, 8'h15, 8'(m << 2));
      for (int c = 0; c < 4; c++)
      begin
        @(negedge clock);
        {bc[0], mc[0], fl[0]} = 3'(4 >> c);
        e = m == 0 || c == 0 || (c == 1 && m < 3) || (c == 2 && m == 1);
        #1 chk("limit", e, lim[0]);
      end
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    t_reset(0);
    t_reset(1);
    t_tag;
    t_ctrl;
    t_limit;
    give_verdict;
  end
  initial
  begin
    #50000;
    fails++;
    give_verdict;
  end
endmodule // tb_port_tag_ratelimit_ctrl
`default_nettype wire
